// ==== ppdm_regs.vh ====
// register offsets, field positions, reset values for the port c/d pin control block
// assumes an apb slave with 32-bit data, one aligned word per register
`ifndef PPDM_REGS_VH
`define PPDM_REGS_VH
// ==================================================
// register byte offsets
`define PPDM_OFF_C_ANSEL 12'h000
`define PPDM_OFF_C_LAT 12'h004
`define PPDM_OFF_C_PORT 12'h008
`define PPDM_OFF_C_DIR 12'h00c
`define PPDM_OFF_D_ANSEL 12'h010
`define PPDM_OFF_D_LAT 12'h014
`define PPDM_OFF_D_PORT 12'h018
`define PPDM_OFF_D_DIR 12'h01c
`define PPDM_OFF_PERIPH 12'h020
`define PPDM_OFF_PINSEL 12'h024
// ==================================================
// reset values
`define PPDM_RST_C_ANSEL 8'hfc
`define PPDM_RST_C_DIR 8'hff
`define PPDM_RST_C_LAT 8'h00
`define PPDM_RST_D_ANSEL 8'hff
`define PPDM_RST_D_DIR 8'hff
`define PPDM_RST_D_LAT 8'h00
`define PPDM_RST_PINSEL 4'hf
// implemented analog-select bits of port c
`define PPDM_C_ANSEL_MASK 8'hfc
// ==================================================
// peripheral enable register fields
`define PPDM_PE_SSP1 0
`define PPDM_PE_SERIAL 1
`define PPDM_PE_SYNC 2
`define PPDM_PE_MASTER 3
`define PPDM_PE_CAPTURE_COMPARE_UNIT_3 4
`define PPDM_PE_PWM3 5
`define PPDM_PE_ALTPKG 6
`define PPDM_PE_WIDTH 7
// pin select register fields
`define PPDM_PS_PWM2B 0
`define PPDM_PS_T3CK 1
`define PPDM_PS_UNIT3 2
`define PPDM_PS_UNIT2 3
`endif

// ==== ppdm_sync.v ====
// three-stage pin synchroniser for a vector of inputs
// assumes inputs are asynchronous to mclk; a change counts once stages two and three agree
module ppdm_sync #(
  parameter WIDTH = 8
) (
  input wire mclk,
  input wire reset,
  input wire ce,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] s1_reg;
  reg [WIDTH-1:0] s2_reg;
  reg [WIDTH-1:0] s3_reg;
  integer i;
  // ==================================================
  // stages and agreement filter
  always @(posedge mclk) begin
    if (reset) begin
      s1_reg <= {WIDTH{1'b0}};
      s2_reg <= {WIDTH{1'b0}};
      s3_reg <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else if (ce) begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (s2_reg[i] == s3_reg[i]) begin
          dout[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule

// ==== ppdm_pin_mux.v ====
// one-pin output arbiter: up to four peripheral drivers in fixed priority, then the latch
// assumes index 0 is highest priority; combinational
module ppdm_pin_mux (
  input wire [3:0] per_en,
  input wire [3:0] per_out,
  input wire dir_bit,
  input wire lat_bit,
  output reg pin_out,
  output reg pin_oe
);
  // ==================================================
  // priority select
  always @* begin
    pin_out = lat_bit;
    pin_oe = ~dir_bit; // R1 R2
    if (per_en[0]) begin // R18
      pin_out = per_out[0];
      pin_oe = 1'b1;
    end else if (per_en[1]) begin
      pin_out = per_out[1];
      pin_oe = 1'b1;
    end else if (per_en[2]) begin
      pin_out = per_out[2];
      pin_oe = 1'b1;
    end else if (per_en[3]) begin
      pin_out = per_out[3];
      pin_oe = 1'b1;
    end
  end
endmodule

// ==== ppdm_port_ctrl.v ====
// port c / port d pin control: direction, latches, pin read, analog gating, peripheral sharing
// assumes an apb master on mclk and pads that resolve out/oe to a wire; pins arrive asynchronous
// Functional notes
// R1 - direction bit one turns pin driver off; pin is an input
// R2 - direction bit zero enables driver and drives latch value
// R3 - output latch addressable; reading it returns latch, not pin level
// R4 - ports eight bits wide, each bit with own direction control
// R5 - after reset port d pins are analog inputs, direction input
// R6 - general latch output unaffected by analog select
// R7 - analog select set disables digital input; port read gives zero
// R8 - port c bit 5 carries serial port 1 data out when active; code drives it only with direction bit 5 zero
// R9 - serial transmit owns port c bit 6 despite direction one
// R10 - port c bit 6 carries sync clock, out as master, in as slave
// R11 - port c bit 7 is async receive input when direction one
// R12 - port c bit 7 carries sync data both ways, direction one
// R13 - port c bit 6: compare/pwm 3 out at dir 0, capture in dir 1
// R14 - port c bits 6,7 carry pwm3 outputs a,b at direction zero
// R15 - four pin select bits: set default pin, clear alternate pin; code relocates unit 3 only, t3ck clear gives timer3 clock 0
// R16 - unimplemented bits read zero, incl. port c analog bits 1,0
// R17 - small package option moves unit 3 outputs off port c
// R18 - several enabled outputs: highest priority peripheral owns pin
// R19 - peripheral outputs drive pin even with analog select set
// R20 - port read gives synced pins; port write updates latch
// R21 - serial overrides direction only while serial unit enabled
`include "ppdm_regs.vh"
module ppdm_port_ctrl #(
  parameter PORT_WIDTH = 8
) (
  input wire mclk,
  input wire reset,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [PORT_WIDTH-1:0] port_c_pin_in,
  output wire [PORT_WIDTH-1:0] port_c_pin_out,
  output wire [PORT_WIDTH-1:0] port_c_pin_oe,
  input wire [PORT_WIDTH-1:0] port_d_pin_in,
  output wire [PORT_WIDTH-1:0] port_d_pin_out,
  output wire [PORT_WIDTH-1:0] port_d_pin_oe,
  input wire sync_serial1_data_out,
  input wire serial_transmit_out,
  input wire serial_sync_clock_out,
  input wire serial_sync_data_out,
  input wire serial_sync_data_oe,
  input wire pwm3_output_a,
  input wire pwm3_output_b,
  input wire unit3_compare_out,
  input wire pwm2_output_b,
  output reg serial_receive_in,
  output reg serial_sync_clock_in,
  output reg serial_sync_data_in,
  output reg unit3_capture_in,
  output reg timer3_clock_in,
  output wire alt_unit3_out,
  output wire alt_unit3_oe,
  output wire alt_pwm3b_out,
  output wire alt_pwm3b_oe,
  output wire [3:0] pin_select_out
);
  // ==================================================
  // registers
  reg [PORT_WIDTH-1:0] c_ansel_reg;
  reg [PORT_WIDTH-1:0] c_lat_reg;
  reg [PORT_WIDTH-1:0] c_dir_reg;
  reg [PORT_WIDTH-1:0] d_ansel_reg;
  reg [PORT_WIDTH-1:0] d_lat_reg;
  reg [PORT_WIDTH-1:0] d_dir_reg;
  reg [`PPDM_PE_WIDTH-1:0] periph_reg;
  reg [3:0] pinsel_reg;
  wire [PORT_WIDTH-1:0] c_sync;
  wire [PORT_WIDTH-1:0] d_sync;
  wire [PORT_WIDTH-1:0] c_rd;
  wire [PORT_WIDTH-1:0] d_rd;
  wire wr_en;
  wire rd_en;
  wire addr_hit;

  function [31:0] ppdm_zext;
    input [PORT_WIDTH-1:0] v;
    begin
      ppdm_zext = 32'h0000_0000;
      ppdm_zext[PORT_WIDTH-1:0] = v;
    end
  endfunction

  // digital input gated by analog select
  function [PORT_WIDTH-1:0] ppdm_gate;
    input [PORT_WIDTH-1:0] pins;
    input [PORT_WIDTH-1:0] ansel;
    begin
      ppdm_gate = pins & ~ansel; // R7
    end
  endfunction

  // ==================================================
  // pin synchronisers
  ppdm_sync #(
    .WIDTH(PORT_WIDTH)
  ) u_sync_c (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .din(port_c_pin_in),
    .dout(c_sync)
  );

  ppdm_sync #(
    .WIDTH(PORT_WIDTH)
  ) u_sync_d (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .din(port_d_pin_in),
    .dout(d_sync)
  );

  assign c_rd = ppdm_gate(c_sync, c_ansel_reg);
  assign d_rd = ppdm_gate(d_sync, d_ansel_reg);

  // ==================================================
  // apb slave: zero wait states, error on unmapped address
  assign pready = 1'b1;
  assign addr_hit = (paddr == `PPDM_OFF_C_ANSEL) || (paddr == `PPDM_OFF_C_LAT) ||
                    (paddr == `PPDM_OFF_C_PORT) || (paddr == `PPDM_OFF_C_DIR) ||
                    (paddr == `PPDM_OFF_D_ANSEL) || (paddr == `PPDM_OFF_D_LAT) ||
                    (paddr == `PPDM_OFF_D_PORT) || (paddr == `PPDM_OFF_D_DIR) ||
                    (paddr == `PPDM_OFF_PERIPH) || (paddr == `PPDM_OFF_PINSEL);
  assign pslverr = psel & penable & ~addr_hit;
  assign wr_en = psel & penable & pwrite & ce & addr_hit;
  assign rd_en = psel & penable & ~pwrite & ce;

  always @(posedge mclk) begin
    if (reset) begin
      c_ansel_reg <= `PPDM_RST_C_ANSEL;
      c_lat_reg <= `PPDM_RST_C_LAT;
      c_dir_reg <= `PPDM_RST_C_DIR;
      d_ansel_reg <= `PPDM_RST_D_ANSEL; // R5
      d_lat_reg <= `PPDM_RST_D_LAT;
      d_dir_reg <= `PPDM_RST_D_DIR; // R5
      periph_reg <= {`PPDM_PE_WIDTH{1'b0}};
      pinsel_reg <= `PPDM_RST_PINSEL;
    end else if (wr_en) begin
      case (paddr)
        `PPDM_OFF_C_ANSEL: c_ansel_reg <= pwdata[PORT_WIDTH-1:0] & `PPDM_C_ANSEL_MASK; // R16
        `PPDM_OFF_C_LAT: c_lat_reg <= pwdata[PORT_WIDTH-1:0]; // R3
        `PPDM_OFF_C_PORT: c_lat_reg <= pwdata[PORT_WIDTH-1:0]; // R20
        `PPDM_OFF_C_DIR: c_dir_reg <= pwdata[PORT_WIDTH-1:0]; // R4
        `PPDM_OFF_D_ANSEL: d_ansel_reg <= pwdata[PORT_WIDTH-1:0];
        `PPDM_OFF_D_LAT: d_lat_reg <= pwdata[PORT_WIDTH-1:0]; // R3
        `PPDM_OFF_D_PORT: d_lat_reg <= pwdata[PORT_WIDTH-1:0]; // R20
        `PPDM_OFF_D_DIR: d_dir_reg <= pwdata[PORT_WIDTH-1:0]; // R4
        `PPDM_OFF_PERIPH: periph_reg <= pwdata[`PPDM_PE_WIDTH-1:0];
        `PPDM_OFF_PINSEL: pinsel_reg <= pwdata[3:0];
        default: periph_reg <= periph_reg;
      endcase
    end
  end

  // read data registered at the access edge; holds otherwise
  always @(posedge mclk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        `PPDM_OFF_C_ANSEL: prdata <= ppdm_zext(c_ansel_reg); // R16
        `PPDM_OFF_C_LAT: prdata <= ppdm_zext(c_lat_reg); // R3
        `PPDM_OFF_C_PORT: prdata <= ppdm_zext(c_rd); // R20
        `PPDM_OFF_C_DIR: prdata <= ppdm_zext(c_dir_reg);
        `PPDM_OFF_D_ANSEL: prdata <= ppdm_zext(d_ansel_reg);
        `PPDM_OFF_D_LAT: prdata <= ppdm_zext(d_lat_reg); // R3
        `PPDM_OFF_D_PORT: prdata <= ppdm_zext(d_rd); // R20
        `PPDM_OFF_D_DIR: prdata <= ppdm_zext(d_dir_reg);
        `PPDM_OFF_PERIPH: prdata <= {25'h0000000, periph_reg};
        `PPDM_OFF_PINSEL: prdata <= {28'h0000000, pinsel_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==================================================
  // peripheral enables
  wire ssp1_en = periph_reg[`PPDM_PE_SSP1];
  wire ser_en = periph_reg[`PPDM_PE_SERIAL];
  wire ser_sync = periph_reg[`PPDM_PE_SYNC];
  wire ser_master = periph_reg[`PPDM_PE_MASTER];
  wire capture_compare_unit_3_en = periph_reg[`PPDM_PE_CAPTURE_COMPARE_UNIT_3];
  wire pwm3_en = periph_reg[`PPDM_PE_PWM3];
  // unit 3 on port c only when default placement and full package not moving it
  wire unit3_here = pinsel_reg[`PPDM_PS_UNIT3] & ~periph_reg[`PPDM_PE_ALTPKG]; // R15 R17
  wire tx_drive = ser_en & ~ser_sync; // R9 R21
  wire ck_drive = ser_en & ser_sync & ser_master; // R10 R21
  wire dt_drive = ser_en & ser_sync & serial_sync_data_oe; // R12 R21
  // pwm/compare need direction zero; serial overrides regardless
  wire p3a_drive = unit3_here & pwm3_en & ~c_dir_reg[6]; // R14
  wire cmp3_drive = unit3_here & capture_compare_unit_3_en & ~pwm3_en & ~c_dir_reg[6]; // R13
  wire p3b_drive = unit3_here & pwm3_en & ~c_dir_reg[7]; // R14
  wire sdo_drive = ssp1_en & ~c_dir_reg[5]; // R8

  assign alt_unit3_out = pwm3_en ? pwm3_output_a : unit3_compare_out;
  assign alt_unit3_oe = ~unit3_here & (pwm3_en | capture_compare_unit_3_en); // R17
  assign alt_pwm3b_out = pwm3_output_b;
  assign alt_pwm3b_oe = ~unit3_here & pwm3_en;
  assign pin_select_out = pinsel_reg; // R15

  // ==================================================
  // per-pin arbitration; analog select not consulted on outputs
  genvar g;
  generate
    for (g = 0; g < PORT_WIDTH; g = g + 1) begin : g_pins
      wire [3:0] c_en;
      wire [3:0] c_val;
      if (g == 5) begin : g_c5
        assign c_en = {3'b000, sdo_drive};
        assign c_val = {3'b000, sync_serial1_data_out};
      end else if (g == 6) begin : g_c6
        assign c_en = {cmp3_drive, p3a_drive, ck_drive, tx_drive}; // R18 R19
        assign c_val = {unit3_compare_out, pwm3_output_a, serial_sync_clock_out, serial_transmit_out};
      end else if (g == 7) begin : g_c7
        assign c_en = {2'b00, p3b_drive, dt_drive}; // R18 R19
        assign c_val = {2'b00, pwm3_output_b, serial_sync_data_out};
      end else begin : g_cx
        assign c_en = 4'h0;
        assign c_val = 4'h0;
      end
      ppdm_pin_mux u_mux_c (
        .per_en(c_en),
        .per_out(c_val),
        .dir_bit(c_dir_reg[g]),
        .lat_bit(c_lat_reg[g]), // R6
        .pin_out(port_c_pin_out[g]),
        .pin_oe(port_c_pin_oe[g])
      );
      ppdm_pin_mux u_mux_d (
        .per_en(4'h0),
        .per_out(4'h0),
        .dir_bit(d_dir_reg[g]),
        .lat_bit(d_lat_reg[g]),
        .pin_out(port_d_pin_out[g]),
        .pin_oe(port_d_pin_oe[g])
      );
    end
  endgenerate

  // ==================================================
  // peripheral inputs, registered from gated synced pins
  always @(posedge mclk) begin
    if (reset) begin
      serial_receive_in <= 1'b1;
      serial_sync_clock_in <= 1'b0;
      serial_sync_data_in <= 1'b0;
      unit3_capture_in <= 1'b0;
      timer3_clock_in <= 1'b0;
    end else if (ce) begin
      serial_receive_in <= c_rd[7] | ~c_dir_reg[7]; // R11
      serial_sync_clock_in <= c_rd[6]; // R10
      serial_sync_data_in <= c_rd[7]; // R12
      unit3_capture_in <= unit3_here & c_dir_reg[6] & c_rd[6]; // R13
      timer3_clock_in <= pinsel_reg[`PPDM_PS_T3CK] ? c_rd[0] : 1'b0; // R15
    end
  end
endmodule

// ==== ppdm_pads.sv ====
// pad model for ports c and d: resolves each pin from the block's drive and the outside level
// assumes the bench supplies the outside level; an undriven pin never keeps the last driven value
module ppdm_pads (
  input wire logic [7:0] c_out,
  input wire logic [7:0] c_oe,
  input wire logic [7:0] d_out,
  input wire logic [7:0] d_oe,
  input wire logic [7:0] ext_c,
  input wire logic [7:0] ext_d,
  output logic [7:0] c_in,
  output logic [7:0] d_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==================================================
  // pin resolution, released pins take the outside level
  assign c_in = (c_out & c_oe) | (ext_c & ~c_oe);
  assign d_in = (d_out & d_oe) | (ext_d & ~d_oe);
endmodule

// ==== ppdm_port_ctrl_asserts.sv ====
// concurrent checks on the port c/d pin control block
// sees top-level ports only; mirrors the direction and peripheral writes itself
`include "ppdm_regs.vh"
module ppdm_chk #(
  parameter PORT_WIDTH = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [PORT_WIDTH-1:0] port_c_pin_out,
  input wire logic [PORT_WIDTH-1:0] port_c_pin_oe,
  input wire logic [PORT_WIDTH-1:0] port_d_pin_out,
  input wire logic [PORT_WIDTH-1:0] port_d_pin_oe,
  input wire logic serial_transmit_out,
  input wire logic serial_sync_clock_out,
  input wire logic serial_sync_data_out,
  input wire logic serial_sync_data_oe,
  input wire logic pwm3_output_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==================================================
  // shadow of the registers that steer port c
  logic wr;
  logic rd;
  logic [PORT_WIDTH-1:0] wd;
  logic [PORT_WIDTH-1:0] coe;
  logic [PORT_WIDTH-1:0] cout;
  logic [PORT_WIDTH-1:0] cdir_reg;
  logic [6:0] pe_reg;
  assign wr = ce && psel && penable && pwrite;
  assign rd = ce && psel && penable && !pwrite;
  assign wd = pwdata[PORT_WIDTH-1:0];
  assign coe = port_c_pin_oe;
  assign cout = port_c_pin_out;
  always_ff @(posedge mclk) begin
    if (reset) begin
      cdir_reg <= '1;
      pe_reg <= '0;
    end else if (wr && paddr == `PPDM_OFF_C_DIR) begin
      cdir_reg <= wd;
    end else if (wr && paddr == `PPDM_OFF_PERIPH) begin
      pe_reg <= pwdata[6:0];
    end
  end
  // ==================================================
  // properties
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);
  property p_rst; $fell(reset) |-> coe == '0 && port_d_pin_oe == '0; endproperty
  a_rst: assert property (p_rst) else $error("pin driven after reset");
  property p_ddir; wr && paddr == `PPDM_OFF_D_DIR |=> port_d_pin_oe == ~$past(wd); endproperty
  a_ddir: assert property (p_ddir) else $error("port d enable");
  property p_dlat;
    wr && (paddr == `PPDM_OFF_D_LAT || paddr == `PPDM_OFF_D_PORT) |=>
      ((port_d_pin_out ^ $past(wd)) & port_d_pin_oe) == '0;
  endproperty
  a_dlat: assert property (p_dlat) else $error("port d drive");
  property p_ansel; rd && paddr == `PPDM_OFF_C_ANSEL |=> prdata[1:0] == 2'b00 && prdata[31:8] == 24'h0; endproperty
  a_ansel: assert property (p_ansel) else $error("ansel read");
  property p_tx; pe_reg[2:1] == 2'b01 |-> coe[6] && cout[6] == serial_transmit_out; endproperty
  a_tx: assert property (p_tx) else $error("transmit pin");
  property p_sclk; pe_reg[3:1] == 3'b111 |-> coe[6] && cout[6] == serial_sync_clock_out; endproperty
  a_sclk: assert property (p_sclk) else $error("sync clock pin");
  property p_sdat; pe_reg[2:1] == 2'b11 && serial_sync_data_oe |-> coe[7] && cout[7] == serial_sync_data_out; endproperty
  a_sdat: assert property (p_sdat) else $error("sync data pin");
  property p_pwm; pe_reg[6:5] == 2'b01 && !pe_reg[1] && !cdir_reg[7] |-> coe[7] && cout[7] == pwm3_output_b; endproperty
  a_pwm: assert property (p_pwm) else $error("pwm pin");
  property p_err; psel && penable && paddr == 12'h028 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");
endmodule
bind ppdm_port_ctrl ppdm_chk #(.PORT_WIDTH(PORT_WIDTH)) ppdm_chk_i (.*);

// ==== tb.sv ====
// self-checking bench for the port c/d pin control block
// assumes an apb slave answering at once; pins resolved by the pad model
`include "ppdm_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, reset = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [7:0] ext_c = 0, ext_d = 0, dir;
  logic sync_serial1_data_out = 0, serial_transmit_out = 0, serial_sync_clock_out = 0;
  logic serial_sync_data_out = 0, serial_sync_data_oe = 0, pwm3_output_a = 0, pwm3_output_b = 0;
  logic unit3_compare_out = 0, pwm2_output_b = 0, rd_flag = 0;
  wire [31:0] prdata;
  wire pready, pslverr, serial_receive_in, serial_sync_clock_in, serial_sync_data_in;
  wire unit3_capture_in, timer3_clock_in, alt_unit3_out, alt_unit3_oe, alt_pwm3b_out, alt_pwm3b_oe;
  wire [7:0] port_c_pin_in, port_c_pin_out, port_c_pin_oe, port_d_pin_in, port_d_pin_out, port_d_pin_oe;
  wire [3:0] pin_select_out;
  logic [31:0] v;
  logic [31:0] expq[$];
  int miscompares = 0, checks = 0, cyc = 0;
  ppdm_port_ctrl ppdm_port_ctrl_i (.*);
  ppdm_pads ppdm_pads_i (.c_out(port_c_pin_out), .c_oe(port_c_pin_oe), .d_out(port_d_pin_out),
    .d_oe(port_d_pin_oe), .ext_c(ext_c), .ext_d(ext_d), .c_in(port_c_pin_in), .d_in(port_d_pin_in));
  initial begin
    forever #4 mclk = ~mclk;
  end
  // ==================================================
  // compares, bus tasks and the read watcher
  task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp_pin(input logic [7:0] g, input logic [7:0] e);
    cmp_rd({24'h0, g}, {24'h0, e});
  endtask
  task automatic pc(input int i, input logic o, input logic x);
    cmp_pin({6'h0, port_c_pin_oe[i], port_c_pin_out[i] & o}, {6'h0, o, x & o});
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    rd_flag <= !w;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    apb(0, a, 32'h0);
  endtask
  // peripheral levels are random so a stuck route shows up
  task automatic cfg(input logic [31:0] pe, input logic [31:0] dr);
    apb(1, `PPDM_OFF_C_DIR, dr);
    apb(1, `PPDM_OFF_PERIPH, pe);
    {pwm3_output_a, pwm3_output_b, unit3_compare_out, serial_sync_data_oe, serial_sync_data_out,
      serial_sync_clock_out, serial_transmit_out, sync_serial1_data_out} <= 8'($urandom);
    ext_c <= 8'($urandom);
    @(posedge mclk);
  endtask
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      summarize;
    end
    if (rd_flag) begin
      rd_flag <= 0;
      cmp_rd(prdata, expq.pop_front());
    end
  end
  // ==================================================
  // tests
  initial begin
    void'($urandom(4));
    repeat (2) @(posedge mclk);
    reset <= 0;
    @(posedge mclk);
    cmp_pin(port_c_pin_oe | port_d_pin_oe, 8'h00);
    rd(`PPDM_OFF_C_ANSEL, 32'hfc);
    rd(`PPDM_OFF_D_ANSEL, 32'hff);
    rd(`PPDM_OFF_D_DIR, 32'hff);
    rd(`PPDM_OFF_D_PORT, 32'h0);
    rd(12'h028, 32'h0);
    rd(`PPDM_OFF_PINSEL, 32'hf);
    $display("reset test done");
    apb(1, `PPDM_OFF_D_ANSEL, 32'h0);
    repeat (4) begin
      v = $urandom;
      dir = 8'($urandom);
      ext_d <= 8'($urandom);
      apb(1, `PPDM_OFF_D_LAT, v);
      apb(1, `PPDM_OFF_D_DIR, {24'($urandom), dir});
      cmp_pin(port_d_pin_oe, ~dir);
      cmp_pin(port_d_pin_out & ~dir, v[7:0] & ~dir);
      repeat (5) @(posedge mclk);
      rd(`PPDM_OFF_D_PORT, {24'h0, (v[7:0] & ~dir) | (ext_d & dir)});
      rd(`PPDM_OFF_D_LAT, {24'h0, v[7:0]});
      apb(1, `PPDM_OFF_D_PORT, ~v);
      rd(`PPDM_OFF_D_LAT, {24'h0, ~v[7:0]});
    end
    apb(1, `PPDM_OFF_D_ANSEL, 32'hff);
    repeat (5) @(posedge mclk);
    rd(`PPDM_OFF_D_PORT, 32'h0);
    cmp_pin(port_d_pin_out & ~dir, ~v[7:0] & ~dir);
    $display("port d test done");
    apb(1, `PPDM_OFF_C_ANSEL, 32'hff);
    rd(`PPDM_OFF_C_ANSEL, 32'hfc);
    apb(1, `PPDM_OFF_C_LAT, 32'h0);
    cfg(32'h02, 32'hff);
    pc(6, 1, serial_transmit_out);
    pc(5, 0, 0);
    cfg(32'h0e, 32'hff);
    pc(6, 1, serial_sync_clock_out);
    pc(7, serial_sync_data_oe, serial_sync_data_out);
    cfg(32'h01, 32'hdf);
    pc(5, 1, sync_serial1_data_out);
    cfg(32'h20, 32'h3f);
    pc(7, 1, pwm3_output_b);
    cfg(32'h22, 32'h3f);
    pc(6, 1, serial_transmit_out);
    cfg(32'h10, 32'hbf);
    pc(6, 1, unit3_compare_out);
    cfg(32'h60, 32'h3f);
    pc(7, 1, 1'b0);
    cmp_pin({6'h0, alt_pwm3b_oe, alt_pwm3b_out}, {6'h0, 1'b1, pwm3_output_b});
    cfg(32'h00, 32'hff);
    pc(6, 0, 0);
    apb(1, `PPDM_OFF_C_ANSEL, 32'h0);
    repeat (6) @(posedge mclk);
    cmp_pin({7'h0, serial_receive_in}, {7'h0, ext_c[7]});
    rd(`PPDM_OFF_C_PORT, {24'h0, ext_c});
    apb(1, `PPDM_OFF_PINSEL, 32'h0);
    cmp_pin({4'h0, pin_select_out}, 8'h00);
    $display("port c test done");
    summarize;
  end
endmodule
